// ### mpc_asserts.sv
`timescale 1ns/1ps
`include "mpc_cfg.svh"
module mpc_check (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // Watched ports
    input wire mpc_pkg::mpc_bus_type bus_in,
    input wire logic [7:0] rdata_out,
    input wire mpc_pkg::mpc_pins_type pins_out,
    input wire logic [6:0] pin_drive_out
);
    import mpc_pkg::*;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    read_idle_zero_a: assert property (!$past(bus_in.rd) |-> rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    ctrl_readback_a: assert property ((bus_in.wr && bus_in.addr == `MPC_ADDR_CH_CTRL) ##1
        (bus_in.rd && bus_in.addr == `MPC_ADDR_CH_CTRL) |=> rdata_out == $past(bus_in.wdata, 2))
        else $error("channel control readback wrong");
    route_reserved_a: assert property (bus_in.rd && bus_in.addr == `MPC_ADDR_ROUTE |=>
        rdata_out[7:6] == 2'b00) else $error("routing reserved bits not zero");
    enable_reserved_a: assert property (bus_in.rd && bus_in.addr == `MPC_ADDR_MOD_EN |=>
        rdata_out[7:6] == 2'b00) else $error("enable reserved bits not zero");
    ch0_route_excl_a: assert property (!(pins_out.port_b_main[0] && pins_out.port_b5))
        else $error("channel 0 on both pins");
    main_route_excl_a: assert property ((pins_out.port_b_main[3:1] &
        pins_out.port_c_alt[3:1]) == 3'h0) else $error("main channel on both pins");
    second_route_a: assert property (!(pins_out.port_d0 && pins_out.port_c6))
        else $error("second modulator on both pins");
    third_route_a: assert property (!(pins_out.port_d1 && pins_out.port_c7))
        else $error("third modulator on both pins");
    spare_undriven_a: assert property (pin_drive_out[0] == 1'b1)
        else $error("spare pin enable driven");
    reset_quiet_a: assert property ($fell(sys_rst_in) |-> {pins_out} == 13'h0000 &&
        pin_drive_out == 7'h7F) else $error("pins not idle after reset");
endmodule : mpc_check
bind mpc_top mpc_check mpc_check_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .bus_in(bus_in), .rdata_out(rdata_out), .pins_out(pins_out), .pin_drive_out(pin_drive_out));

// ### mpc_cfg.svh
`ifndef MPC_CFG_SVH
`define MPC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MPC_ADDR_MOD_EN 8'hA2
`define MPC_ADDR_CH_CTRL 8'hA3
`define MPC_ADDR_CH0_DL 8'hA4
`define MPC_ADDR_CH0_DH 8'hA5
`define MPC_ADDR_CH1_DL 8'hA6
`define MPC_ADDR_CH1_DH 8'hA7
`define MPC_ADDR_CH2_DL 8'hA9
`define MPC_ADDR_CH2_DH 8'hAA
`define MPC_ADDR_CH3_DL 8'hAB
`define MPC_ADDR_CH3_DH 8'hAC
`define MPC_ADDR_PER_L 8'hAD
`define MPC_ADDR_PER_H 8'hAE
`define MPC_ADDR_ROUTE 8'hB2
`define MPC_ADDR_M1_LOW_L 8'h99
`define MPC_ADDR_M1_LOW_H 8'h9A
`define MPC_ADDR_M1_HIGH_L 8'h9B
`define MPC_ADDR_M1_HIGH_H 8'h9C
`define MPC_ADDR_M2_LOW_L 8'h9D
`define MPC_ADDR_M2_LOW_H 8'h9E
`define MPC_ADDR_M2_HIGH_L 8'h9F
`define MPC_ADDR_M2_HIGH_H 8'hA1

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define MPC_EN_MAIN_BIT 0
`define MPC_EN_SECOND_BIT 1
`define MPC_EN_THIRD_BIT 2
`define MPC_BORROW_LSB 3
`define MPC_POL_LSB 4
`define MPC_CHEN_LSB 0
`define MPC_ROUTE_SECOND_BIT 4
`define MPC_ROUTE_THIRD_BIT 5
`define MPC_MOD_EN_MASK 8'h3F
`define MPC_ROUTE_MASK 8'h3F
`define MPC_RESET_BYTE 8'h00

`endif

// ### mpc_load.sv
`timescale 1ns/1ps
module mpc_load (
    // Clock and count window
    input wire logic sys_clk_in,
    input wire logic window_in,
    // Pin levels seen by the loads
    input wire mpc_pkg::mpc_pins_type pins_in,
    // High cycles per pin bit within the window
    output logic [12:0][7:0] high_cnt_out
);
    import mpc_pkg::*;
    logic [12:0] level;
    assign level = pins_in;
    // Cleared outside the window so each measurement starts fresh
    always_ff @(posedge sys_clk_in) begin
        for (int i = 0; i < 13; i++) begin
            high_cnt_out[i] <= window_in ? high_cnt_out[i] + {7'h00, level[i]} : 8'h00;
        end
    end
endmodule : mpc_load

// ### mpc_pkg.sv
package mpc_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } mpc_bus_type;

    typedef struct packed {
        logic [3:0] port_b_main;
        logic [3:0] port_c_alt;
        logic port_b5;
        logic port_d0;
        logic port_d1;
        logic port_c6;
        logic port_c7;
    } mpc_pins_type;

    typedef enum logic {
        MPC_PHASE_LOW,
        MPC_PHASE_HIGH
    } mpc_phase_type;
endpackage : mpc_pkg

// ### mpc_top.sv
`timescale 1ns/1ps
`include "mpc_cfg.svh"
// What this block does
// - Channels 1-3 use channel 0 duty when their borrow bit is set.
// - Enable bits 0..2 switch on main, second and third modulators.
// - Polarity bits 7..4: 1 makes wrap drive low, 0 drives high.
// - Channel enable bits 3..0 gate each main channel output.
// - Each main channel holds a 16-bit duty from low and high bytes.
// - One 16-bit period from low and high bytes serves all channels.
// - Routing bit 5 moves third modulator from port D1 to C7.
// - Routing bit 4 moves second modulator from port D0 to C6.
// - Routing bit 3 moves channel 3 from port B3 to C5.
// - Routing bit 2 moves channel 2 from port B2 to C3.
// - Routing bit 1 moves channel 1 from port B1 to C0.
// - Routing bit 0 moves channel 0 from port B0 to both B5 and port_c_alt[0].
// - Second and third modulators use 16-bit low and high durations.
module mpc_top (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // Register port
    input wire mpc_pkg::mpc_bus_type bus_in,
    output logic [7:0] rdata_out,
    // Pins
    output mpc_pkg::mpc_pins_type pins_out,
    output logic [6:0] pin_drive_out
);
    import mpc_pkg::*;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] mod_enable;
    logic [7:0] main_channel_control;
    logic [7:0] output_pin_routing;
    logic [7:0] duty_low [4];
    logic [7:0] duty_high [4];
    logic [7:0] period_low;
    logic [7:0] period_high;
    logic [7:0] dur_reg [8];

    wire wr = bus_in.wr;
    wire [7:0] a = bus_in.addr;
    wire [7:0] wd = bus_in.wdata;

    // Register write decode: duty table index for each channel
    logic [7:0] duty_l_addr [4];
    logic [7:0] duty_h_addr [4];
    logic [7:0] dur_addr [8];
    assign duty_l_addr[0] = `MPC_ADDR_CH0_DL;
    assign duty_h_addr[0] = `MPC_ADDR_CH0_DH;
    assign duty_l_addr[1] = `MPC_ADDR_CH1_DL;
    assign duty_h_addr[1] = `MPC_ADDR_CH1_DH;
    assign duty_l_addr[2] = `MPC_ADDR_CH2_DL;
    assign duty_h_addr[2] = `MPC_ADDR_CH2_DH;
    assign duty_l_addr[3] = `MPC_ADDR_CH3_DL;
    assign duty_h_addr[3] = `MPC_ADDR_CH3_DH;
    assign dur_addr[0] = `MPC_ADDR_M1_LOW_L;
    assign dur_addr[1] = `MPC_ADDR_M1_LOW_H;
    assign dur_addr[2] = `MPC_ADDR_M1_HIGH_L;
    assign dur_addr[3] = `MPC_ADDR_M1_HIGH_H;
    assign dur_addr[4] = `MPC_ADDR_M2_LOW_L;
    assign dur_addr[5] = `MPC_ADDR_M2_LOW_H;
    assign dur_addr[6] = `MPC_ADDR_M2_HIGH_L;
    assign dur_addr[7] = `MPC_ADDR_M2_HIGH_H;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            mod_enable <= `MPC_RESET_BYTE;
            main_channel_control <= `MPC_RESET_BYTE;
            output_pin_routing <= `MPC_RESET_BYTE;
            period_low <= `MPC_RESET_BYTE;
            period_high <= `MPC_RESET_BYTE;
        end else if (wr) begin
            if (a == `MPC_ADDR_MOD_EN) mod_enable <= wd & `MPC_MOD_EN_MASK;
            if (a == `MPC_ADDR_CH_CTRL) main_channel_control <= wd;
            if (a == `MPC_ADDR_ROUTE) output_pin_routing <= wd & `MPC_ROUTE_MASK;
            if (a == `MPC_ADDR_PER_L) period_low <= wd;
            if (a == `MPC_ADDR_PER_H) period_high <= wd;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_duty
            always_ff @(posedge sys_clk_in) begin
                if (sys_rst_in) begin
                    duty_low[gi] <= `MPC_RESET_BYTE;
                    duty_high[gi] <= `MPC_RESET_BYTE;
                end else if (wr) begin
                    if (a == duty_l_addr[gi]) duty_low[gi] <= wd;
                    if (a == duty_h_addr[gi]) duty_high[gi] <= wd;
                end
            end
        end
        for (gi = 0; gi < 8; gi++) begin : g_dur
            always_ff @(posedge sys_clk_in) begin
                if (sys_rst_in) begin
                    dur_reg[gi] <= `MPC_RESET_BYTE;
                end else if (wr && a == dur_addr[gi]) begin
                    dur_reg[gi] <= wd;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        case (a)
            `MPC_ADDR_MOD_EN: next_rdata = mod_enable;
            `MPC_ADDR_CH_CTRL: next_rdata = main_channel_control;
            `MPC_ADDR_ROUTE: next_rdata = output_pin_routing;
            `MPC_ADDR_PER_L: next_rdata = period_low;
            `MPC_ADDR_PER_H: next_rdata = period_high;
            default: next_rdata = 8'h00;
        endcase
        for (int i = 0; i < 4; i++) begin
            if (a == duty_l_addr[i]) next_rdata = duty_low[i];
            if (a == duty_h_addr[i]) next_rdata = duty_high[i];
        end
        for (int j = 0; j < 8; j++) begin
            if (a == dur_addr[j]) next_rdata = dur_reg[j];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) rdata_out <= 8'h00;
        else if (bus_in.rd) rdata_out <= next_rdata;
        else rdata_out <= 8'h00;
    end

    // ----------------------------------------
    // Main modulator
    // ----------------------------------------
    // Shadowed period and duties reload only at wrap or while held off, so a half-written 16-bit
    // value never lands in the middle of a cycle.
    logic [15:0] count;
    logic [15:0] period_act;
    logic [15:0] duty_act [4];
    logic [3:0] main_level;
    wire main_on = mod_enable[`MPC_EN_MAIN_BIT];
    wire wrap = (count >= period_act);
    wire [3:0] polarity = main_channel_control[`MPC_POL_LSB +: 4];
    wire [3:0] ch_en = main_channel_control[`MPC_CHEN_LSB +: 4];
    wire [2:0] borrow = mod_enable[`MPC_BORROW_LSB +: 3];
    logic [15:0] duty_sel [4];

    assign duty_sel[0] = {duty_high[0], duty_low[0]};
    generate
        for (gi = 1; gi < 4; gi++) begin : g_borrow
            assign duty_sel[gi] = borrow[gi-1] ? duty_sel[0]
                                               : {duty_high[gi], duty_low[gi]};
        end
    endgenerate

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || !main_on) begin
            count <= 16'h0000;
            period_act <= {period_high, period_low};
        end else if (wrap) begin
            count <= 16'h0000;
            period_act <= {period_high, period_low};
        end else begin
            count <= count + 16'h0001;
        end
    end

    generate
        for (gi = 0; gi < 4; gi++) begin : g_chan
            always_ff @(posedge sys_clk_in) begin
                if (sys_rst_in || !main_on || !ch_en[gi]) begin
                    duty_act[gi] <= duty_sel[gi];
                    main_level[gi] <= polarity[gi];
                end else if (wrap) begin
                    duty_act[gi] <= duty_sel[gi];
                    main_level[gi] <= ~polarity[gi];
                end else if (count + 16'h0001 == duty_act[gi]) begin
                    main_level[gi] <= polarity[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Second and third modulators
    // ----------------------------------------
    logic [1:0] sm_level;
    logic [15:0] sm_count [2];
    generate
        for (gi = 0; gi < 2; gi++) begin : g_single
            wire on = mod_enable[`MPC_EN_SECOND_BIT + gi];
            wire [15:0] low_len = {dur_reg[4*gi+1], dur_reg[4*gi]};
            wire [15:0] high_len = {dur_reg[4*gi+3], dur_reg[4*gi+2]};
            wire [15:0] cur_len = sm_level[gi] ? high_len : low_len;
            always_ff @(posedge sys_clk_in) begin
                if (sys_rst_in || !on) begin
                    sm_level[gi] <= 1'b0;
                    sm_count[gi] <= 16'h0000;
                end else if (sm_count[gi] >= cur_len) begin
                    sm_level[gi] <= ~sm_level[gi];
                    sm_count[gi] <= 16'h0000;
                end else begin
                    sm_count[gi] <= sm_count[gi] + 16'h0001;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Pin routing
    // ----------------------------------------
    // Unselected pins idle low; pin_drive_out low means the pin is driven.
    wire [5:0] rsel = output_pin_routing[5:0];
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pins_out <= '0;
            pin_drive_out <= 7'h7F;
        end else begin
            pins_out.port_b_main <= main_level & ~rsel[3:0];
            pins_out.port_c_alt <= main_level & rsel[3:0];
            pins_out.port_b5 <= main_level[0] & rsel[0];
            pins_out.port_d0 <= sm_level[0] & ~rsel[`MPC_ROUTE_SECOND_BIT];
            pins_out.port_c6 <= sm_level[0] & rsel[`MPC_ROUTE_SECOND_BIT];
            pins_out.port_d1 <= sm_level[1] & ~rsel[`MPC_ROUTE_THIRD_BIT];
            pins_out.port_c7 <= sm_level[1] & rsel[`MPC_ROUTE_THIRD_BIT];
            pin_drive_out <= ~{main_on & ch_en[0],
                               mod_enable[`MPC_EN_SECOND_BIT],
                               mod_enable[`MPC_EN_THIRD_BIT],
                               main_on & ch_en[1], main_on & ch_en[2],
                               main_on & ch_en[3], 1'b0};
        end
    end
endmodule : mpc_top

// ### mpc_top_bench.sv
`timescale 1ns/1ps
`include "mpc_cfg.svh"
module mpc_top_bench;
    import mpc_pkg::*;
    logic sys_clk_in;
    logic sys_rst_in;
    logic win;
    mpc_bus_type bus;
    logic [7:0] rdata;
    mpc_pins_type pins;
    logic [6:0] drv_n;
    logic [12:0][7:0] cnt;
    int miscompares = 0;
    int n_compared = 0;
    mpc_top mpc_top_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .bus_in(bus),
        .rdata_out(rdata), .pins_out(pins), .pin_drive_out(drv_n));
    mpc_load mpc_load_inst (.sys_clk_in(sys_clk_in), .window_in(win), .pins_in(pins),
        .high_cnt_out(cnt));
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk_in) bus <= '0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk_in) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk_in) bus <= '0;
        #1 chk("rdata", exp, rdata);
    endtask : rd
    // Whole periods of every waveform fit the 40-cycle window
    task meas(input int settle);
        repeat (settle) @(posedge sys_clk_in);
        win <= 1'b1;
        repeat (40) @(posedge sys_clk_in);
        win <= 1'b0;
        #1;
    endtask : meas
    task test_regs;
        chk("drive", 8'h7F, {1'b0, drv_n});
        for (int a = 8'hA0; a <= 8'hAE; a++) rd(a[7:0], 8'h00);
        rd(`MPC_ADDR_ROUTE, 8'h00);
        wr(`MPC_ADDR_ROUTE, 8'hFF);
        rd(`MPC_ADDR_ROUTE, 8'h3F);
        wr(`MPC_ADDR_MOD_EN, 8'hFF);
        rd(`MPC_ADDR_MOD_EN, 8'h3F);
        @(posedge sys_clk_in) bus <= '{`MPC_ADDR_CH_CTRL, 8'hA5, 1'b1, 1'b0};
        rd(`MPC_ADDR_CH_CTRL, 8'hA5);
        wr(`MPC_ADDR_PER_H, 8'h12);
        rd(`MPC_ADDR_PER_H, 8'h12);
        wr(`MPC_ADDR_ROUTE, 8'h00);
        wr(`MPC_ADDR_MOD_EN, 8'h00);
        $display("test_regs done");
    endtask : test_regs
    task test_main;
        wr(`MPC_ADDR_PER_H, 8'h00);
        wr(`MPC_ADDR_PER_L, 8'h09);
        wr(`MPC_ADDR_CH0_DL, 8'h03);
        wr(`MPC_ADDR_CH1_DL, 8'h07);
        wr(`MPC_ADDR_CH_CTRL, 8'h03);
        wr(`MPC_ADDR_MOD_EN, 8'h01);
        meas(30);
        chk("ch0_high", 8'h0C, cnt[9]);
        chk("ch1_high", 8'h1C, cnt[10]);
        wr(`MPC_ADDR_MOD_EN, 8'h09);
        meas(30);
        chk("ch1_borrow", 8'h0C, cnt[10]);
        wr(`MPC_ADDR_CH_CTRL, 8'h13);
        meas(30);
        chk("ch0_pol", 8'h1C, cnt[9]);
        wr(`MPC_ADDR_CH_CTRL, 8'h12);
        meas(30);
        chk("ch0_off", 8'h28, cnt[9]);
        wr(`MPC_ADDR_MOD_EN, 8'h00);
        meas(30);
        chk("ch1_main_off", 8'h00, cnt[10]);
        $display("test_main done");
    endtask : test_main
    task test_route;
        wr(`MPC_ADDR_CH_CTRL, 8'h0F);
        wr(`MPC_ADDR_MOD_EN, 8'h39);
        for (int r = 0; r < 2; r++) begin
            wr(`MPC_ADDR_ROUTE, r ? 8'h0F : 8'h00);
            meas(30);
            for (int i = 0; i < 4; i++) chk("main_pin", r ? 8'h00 : 8'h0C, cnt[9+i]);
            for (int i = 1; i < 4; i++) chk("alt_pin", r ? 8'h0C : 8'h00, cnt[5+i]);
            chk("b5_pin", r ? 8'h0C : 8'h00, cnt[4]);
            chk("drive", 8'h31, {1'b0, drv_n});
        end
        wr(`MPC_ADDR_ROUTE, 8'h00);
        $display("test_route done");
    endtask : test_route
    task test_single;
        wr(`MPC_ADDR_M1_LOW_L, 8'h02);
        wr(`MPC_ADDR_M1_HIGH_L, 8'h04);
        wr(`MPC_ADDR_M2_LOW_L, 8'h03);
        wr(`MPC_ADDR_M2_HIGH_L, 8'h03);
        wr(`MPC_ADDR_MOD_EN, 8'h06);
        for (int r = 0; r < 2; r++) begin
            wr(`MPC_ADDR_ROUTE, r ? 8'h30 : 8'h00);
            meas(24);
            chk("d0_pin", r ? 8'h00 : 8'h19, cnt[3]);
            chk("c6_pin", r ? 8'h19 : 8'h00, cnt[1]);
            chk("d1_pin", r ? 8'h00 : 8'h14, cnt[2]);
            chk("c7_pin", r ? 8'h14 : 8'h00, cnt[0]);
            chk("drive", 8'h4F, {1'b0, drv_n});
        end
        $display("test_single done");
    endtask : test_single
    task stop_test;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    initial begin
        sys_rst_in = 1'b1;
        bus = '0;
        win = 1'b0;
        repeat (12) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        test_regs;
        test_main;
        test_route;
        test_single;
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        miscompares++;
        stop_test;
    end
endmodule : mpc_top_bench
